//--- include/hwm_pkg.sv
// Constants and carrier types for the hardware monitor port block
package hwm_pkg;
   // Low index map
   localparam logic [6:0] IDX_CFG = 7'h40;
   localparam logic [6:0] IDX_STAT1 = 7'h41;
   localparam logic [6:0] IDX_STAT2 = 7'h42;
   localparam logic [6:0] IDX_MASK1 = 7'h43;
   localparam logic [6:0] IDX_MASK2 = 7'h44;
   localparam logic [6:0] IDX_NMSK1 = 7'h45;
   localparam logic [6:0] IDX_NMSK2 = 7'h46;
   localparam logic [6:0] IDX_FANDIV = 7'h47;
   localparam logic [6:0] IDX_DEVID = 7'h49;
   localparam logic [6:0] IDX_PROP = 7'h4C;
   localparam logic [6:0] IDX_FANIO = 7'h4D;
   localparam logic [6:0] IDX_BANK = 7'h4E;
   localparam logic [6:0] IDX_VENDOR = 7'h4F;
   // Banked window 50h-5Fh, sensor 2 page
   localparam logic [2:0] BANK_WIN = 3'h5;
   localparam logic [2:0] BANK_TEMP2 = 3'h1;
   localparam logic [2:0] BANK_TEMP3 = 3'h2;
   localparam logic [6:0] IDX_B_TEMP = 7'h50;
   localparam logic [6:0] IDX_B_TLSB = 7'h51;
   localparam logic [6:0] IDX_B_CFG = 7'h52;
   localparam logic [6:0] IDX_B_HYST = 7'h53;
   localparam logic [6:0] IDX_B_OVER = 7'h55;
   // RAM windows
   localparam logic [6:0] IDX_RAM_END = 7'h3F;
   localparam logic [6:0] IDX_ALIAS_LO = 7'h60;
   // Field positions
   localparam int BUSY_BIT = 7;
   localparam int CFG_INIT_BIT = 7;
   localparam int CFG_STOP_BIT = 3;
   localparam int CFG_IRQEN_BIT = 1;
   localparam int CFG_RUN_BIT = 0;
   localparam int PROP_S2MODE_BIT = 6;
   localparam int BCFG_OVTMODE_BIT = 2;
   localparam int STAT_S2_BIT = 5;
   // Reset values
   localparam logic [6:0] PTR_RST = 7'h00;
   localparam logic [7:0] CFG_RST = 8'h08;
   localparam logic [7:0] ZERO_RST = 8'h00;
   localparam logic [7:0] NMSK2_RST = 8'h40;
   localparam logic [7:0] FANDIV_RST = 8'h50;
   localparam logic [7:0] FANIO_RST = 8'h15;
   localparam logic [7:0] BANK_RST = 8'h80;
   localparam logic [7:0] HYST_RST = 8'h4B;
   localparam logic [7:0] OVER_RST = 8'h50;
   // Identity values, arbitrary
   localparam logic [7:0] DEVICE_ID = 8'h0A;
   localparam logic [7:0] VENDOR_HI = 8'h12;
   localparam logic [7:0] VENDOR_LO = 8'h34;
   // Alert trackers
   typedef enum logic [1:0] {THERM_COOL = 2'b01, THERM_HOT = 2'b10} hwm_therm_t;
   // Host port strobe group
   typedef struct packed {logic sel; logic rd; logic wr; logic [7:0] wdata;} hwm_port_req_t;
   // Sensor 2 conversion result
   typedef struct packed {logic [7:0] temp; logic conv_done;} hwm_sense_t;
endpackage

//--- core/hwm_core.sv
// Hardware monitor index/data ports, mask logic and sensor 2 alert outputs
`timescale 1ns/1ns
// What this block does
// - Property bit 6 picks comparator or two-times mode for sensor 2 interrupt
// - Comparator: over-limit raises interrupt; reading status registers clears it
// - Comparator: cleared but still above hysteresis, re-raise on next conversion
// - Comparator: no new sensor 2 events while the raised one is uncleared
// - Comparator: repeat raise-clear-reraise until temperature drops below hysteresis
// - Two-times: interrupt on over-limit, again below hysteresis once cleared
// - Two-times: after clearing, stay quiet while above hysteresis
// - Over-temperature output follows sensor 2 only; a sensor 3 page temperature read also releases latched mode
// - Bank 52h bit 2 clear selects comparator over-temperature mode
// - Comparator output asserts above limit, holds until below hysteresis
// - Bank 52h bit 2 set selects latched over-temperature mode
// - Latched mode: assert above limit, release on temperature register read
// - Latched mode: after release, latch again when falling below hysteresis
// - Latched mode: after release, no reassert while above hysteresis
// - Index port: 7-bit pointer resetting to 00h, read-only busy bit 7
// - Busy sets on index port write or during serial-bus transaction
// - Busy set by index write clears on next data port access
// - Data access at 41h advances pointer to 42h
// - Data access at 43h advances pointer to 44h
// - Data access at 45h advances pointer to 46h
// - Data port reads and writes the location the pointer selects
// - Management interrupt driven only while config bit 1 is set
// - Mask bit set keeps its status bit from raising the interrupt
module hwm_core (
   input wire logic ref_clk,
   input wire logic reset_n,
   input wire hwm_pkg::hwm_port_req_t port_req,
   input wire hwm_pkg::hwm_sense_t sense,
   input wire logic [15:0] status_evt,
   input wire logic serial_busy,
   output logic [7:0] port_rdata_q,
   output logic mgmt_interrupt_out_n,
   output logic overtemp_alert_out_n
);
   import hwm_pkg::*;

   logic idx_wr, data_rd, data_wr, data_acc;
   logic [6:0] ptr_q;
   logic busy_q;
   logic pair_lo, soft_init, bank_hit, ram_hit;
   logic [5:0] ram_idx;
   logic [7:0] ram_q [64];
   logic [7:0] cfg_q, mask1_q, mask2_q, nmsk1_q, nmsk2_q;
   logic [7:0] fandiv_q, prop_q, fanio_q, bank_q;
   logic [7:0] bcfg_q, hyst_q, over_q;
   logic [15:0] stat_q, stat_set, stat_clr, mask_all;
   logic conv, t_hi, t_lo, temp_rd;
   logic s2_two, s2_pend, s2_evt;
   hwm_therm_t s2_st_q, s2_st_d;
   logic ovt_int, ovt_set;
   hwm_therm_t ovt_st_q, ovt_st_d;
   logic [7:0] rd_mux;

   // Port strobe decode; sel low is the index port, high the data port
   assign idx_wr = port_req.wr & ~port_req.sel;
   assign data_rd = port_req.rd & port_req.sel;
   assign data_wr = port_req.wr & port_req.sel;
   assign data_acc = data_rd | data_wr;

   // Location decode for the current pointer
   assign pair_lo = (ptr_q == IDX_STAT1) | (ptr_q == IDX_MASK1) | (ptr_q == IDX_NMSK1);
   assign bank_hit = (ptr_q[6:4] == BANK_WIN);
   assign ram_hit = (ptr_q <= IDX_RAM_END) | (ptr_q >= IDX_ALIAS_LO);
   assign ram_idx = (ptr_q >= IDX_ALIAS_LO) ? {1'b1, ptr_q[4:0]} : ptr_q[5:0];
   assign soft_init = data_wr & (ptr_q == IDX_CFG) & port_req.wdata[CFG_INIT_BIT];

   // Index pointer load and auto-increment over the paired registers
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         ptr_q <= PTR_RST;
      end else if (idx_wr) begin
         ptr_q <= port_req.wdata[6:0];
      end else if (data_acc && pair_lo) begin // other data accesses hold
         ptr_q <= ptr_q + 7'h01;
      end
   end

   // Busy flag owned by the host port; serial activity is merged on read
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         busy_q <= 1'b0;
      end else if (idx_wr) begin
         busy_q <= 1'b1;
      end else if (data_acc) begin
         busy_q <= 1'b0;
      end
   end

   // POST and value RAM; upper window aliases the value area
   always_ff @(posedge ref_clk) begin
      if (data_wr && ram_hit) begin
         ram_q[ram_idx] <= port_req.wdata;
      end
   end

   // Configuration, mask and control registers; init bit restores defaults
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         cfg_q <= CFG_RST;
         mask1_q <= ZERO_RST;
         mask2_q <= ZERO_RST;
         nmsk1_q <= ZERO_RST;
         nmsk2_q <= NMSK2_RST;
         fandiv_q <= FANDIV_RST;
         prop_q <= ZERO_RST;
         fanio_q <= FANIO_RST;
         bank_q <= BANK_RST;
      end else if (soft_init) begin
         cfg_q <= CFG_RST;
         mask1_q <= ZERO_RST;
         mask2_q <= ZERO_RST;
         nmsk1_q <= ZERO_RST;
         nmsk2_q <= NMSK2_RST;
         fandiv_q <= FANDIV_RST;
         prop_q <= ZERO_RST;
         fanio_q <= FANIO_RST;
         bank_q <= BANK_RST;
      end else if (data_wr) begin
         case (ptr_q)
            IDX_CFG: cfg_q <= port_req.wdata;
            IDX_MASK1: mask1_q <= port_req.wdata;
            IDX_MASK2: mask2_q <= {2'b00, port_req.wdata[5:0]};
            IDX_NMSK1: nmsk1_q <= port_req.wdata;
            IDX_NMSK2: nmsk2_q <= port_req.wdata;
            IDX_FANDIV: fandiv_q <= {port_req.wdata[7:4], 4'h0};
            IDX_PROP: prop_q <= port_req.wdata;
            IDX_FANIO: fanio_q <= port_req.wdata;
            IDX_BANK: bank_q <= {port_req.wdata[7], 4'h0, port_req.wdata[2:0]};
            default: ;
         endcase
      end
   end

   // Sensor 2 page in the banked window: mode, hysteresis and limit
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         bcfg_q <= ZERO_RST;
         hyst_q <= HYST_RST;
         over_q <= OVER_RST;
      end else if (soft_init) begin
         bcfg_q <= ZERO_RST;
         hyst_q <= HYST_RST;
         over_q <= OVER_RST;
      end else if (data_wr && bank_q[2:0] == BANK_TEMP2) begin
         case (ptr_q)
            IDX_B_CFG: bcfg_q <= port_req.wdata;
            IDX_B_HYST: hyst_q <= port_req.wdata;
            IDX_B_OVER: over_q <= port_req.wdata;
            default: ;
         endcase
      end
   end

   // Conversion qualifier and signed comparisons against the limits
   assign conv = sense.conv_done & cfg_q[CFG_RUN_BIT] & ~cfg_q[CFG_STOP_BIT];
   assign t_hi = $signed(sense.temp) > $signed(over_q);
   assign t_lo = $signed(sense.temp) < $signed(hyst_q);
   assign temp_rd = data_rd & bank_hit & (ptr_q[6:1] == IDX_B_TEMP[6:1])
      & ((bank_q[2:0] == BANK_TEMP2) | (bank_q[2:0] == BANK_TEMP3));

   // Sensor 2 interrupt tracker; a pending status bit blocks new events
   assign s2_two = prop_q[PROP_S2MODE_BIT];
   assign s2_pend = stat_q[STAT_S2_BIT];
   always_comb begin
      s2_evt = 1'b0;
      s2_st_d = s2_st_q;
      if (conv) begin
         unique case (s2_st_q)
            THERM_COOL: begin
               if (t_hi) begin
                  s2_evt = ~s2_pend;
                  s2_st_d = (s2_two && s2_pend) ? THERM_COOL : THERM_HOT;
               end
            end
            THERM_HOT: begin
               if (t_lo) begin
                  s2_evt = s2_two & ~s2_pend;
                  s2_st_d = (s2_two && s2_pend) ? THERM_HOT : THERM_COOL;
               end else begin
                  s2_evt = ~s2_two & ~s2_pend;
               end
            end
         endcase
      end
   end

   // Sensor 2 tracker state
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         s2_st_q <= THERM_COOL;
      end else begin
         s2_st_q <= s2_st_d;
      end
   end

   // Status bits: reading a status register clears it, a new event wins
   assign stat_set = status_evt | {10'h000, s2_evt, 5'h00};
   assign stat_clr = {{8{data_rd && ptr_q == IDX_STAT2}}, {8{data_rd && ptr_q == IDX_STAT1}}};
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         stat_q <= 16'h0000;
      end else if (soft_init) begin
         stat_q <= stat_set;
      end else begin
         stat_q <= (stat_q & ~stat_clr) | stat_set;
      end
   end

   // Management interrupt: enabled, not stopped, any unmasked status bit
   assign mask_all = {mask2_q, mask1_q};
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         mgmt_interrupt_out_n <= 1'b1;
      end else begin
         mgmt_interrupt_out_n <= ~(cfg_q[CFG_IRQEN_BIT] & ~cfg_q[CFG_STOP_BIT]
            & (|(stat_q & ~mask_all)));
      end
   end

   // Over-temperature tracker for latched mode, fed by sensor 2 only
   assign ovt_int = bcfg_q[BCFG_OVTMODE_BIT];
   always_comb begin
      ovt_set = 1'b0;
      ovt_st_d = ovt_st_q;
      if (conv) begin
         unique case (ovt_st_q)
            THERM_COOL: begin
               if (t_hi) begin
                  ovt_set = 1'b1;
                  ovt_st_d = THERM_HOT;
               end
            end
            THERM_HOT: begin
               if (t_lo) begin
                  ovt_set = 1'b1;
                  ovt_st_d = THERM_COOL;
               end
            end
         endcase
      end
   end

   // Over-temperature tracker state
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         ovt_st_q <= THERM_COOL;
      end else begin
         ovt_st_q <= ovt_st_d;
      end
   end

   // Over-temperature pin: comparator follows limits, latched waits for a read
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         overtemp_alert_out_n <= 1'b1;
      end else if (ovt_int) begin
         if (ovt_set) begin
            overtemp_alert_out_n <= 1'b0;
         end else if (temp_rd) begin
            overtemp_alert_out_n <= 1'b1;
         end
      end else if (conv && t_hi) begin
         overtemp_alert_out_n <= 1'b0;
      end else if (conv && t_lo) begin
         overtemp_alert_out_n <= 1'b1;
      end
   end

   // Read mux for both ports
   always_comb begin
      rd_mux = 8'h00;
      if (!port_req.sel) begin
         rd_mux = {busy_q | serial_busy, ptr_q};
      end else if (ram_hit) begin
         rd_mux = ram_q[ram_idx];
      end else if (bank_hit) begin
         if (bank_q[2:0] == BANK_TEMP2) begin
            case (ptr_q)
               IDX_B_TEMP: rd_mux = sense.temp;
               IDX_B_CFG: rd_mux = bcfg_q;
               IDX_B_HYST: rd_mux = hyst_q;
               IDX_B_OVER: rd_mux = over_q;
               default: rd_mux = 8'h00;
            endcase
         end
      end else begin
         case (ptr_q)
            IDX_CFG: rd_mux = cfg_q;
            IDX_STAT1: rd_mux = stat_q[7:0];
            IDX_STAT2: rd_mux = stat_q[15:8];
            IDX_MASK1: rd_mux = mask1_q;
            IDX_MASK2: rd_mux = mask2_q;
            IDX_NMSK1: rd_mux = nmsk1_q;
            IDX_NMSK2: rd_mux = nmsk2_q;
            IDX_FANDIV: rd_mux = fandiv_q;
            IDX_DEVID: rd_mux = DEVICE_ID;
            IDX_PROP: rd_mux = prop_q;
            IDX_FANIO: rd_mux = fanio_q;
            IDX_BANK: rd_mux = bank_q;
            IDX_VENDOR: rd_mux = bank_q[BUSY_BIT] ? VENDOR_HI : VENDOR_LO;
            default: rd_mux = 8'h00;
         endcase
      end
   end

   // Read data register, loaded on any read strobe
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         port_rdata_q <= 8'h00;
      end else if (port_req.rd) begin
         port_rdata_q <= rd_mux;
      end
   end

   // Checks on the port and alert behaviour
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!reset_n);

   a_busy_set: assert property (idx_wr |=> busy_q)
      else $error("busy not set by index write");
   a_busy_clear: assert property (busy_q && data_acc |=> !busy_q)
      else $error("busy not cleared by data access");
   a_ptr_load: assert property (idx_wr |=> ptr_q == $past(port_req.wdata[6:0]))
      else $error("pointer not loaded");
   a_incr_stat: assert property (data_acc && ptr_q == IDX_STAT1 |=> ptr_q == IDX_STAT2)
      else $error("no increment from 41h");
   a_incr_mask: assert property (data_acc && ptr_q == IDX_MASK1 |=> ptr_q == IDX_MASK2)
      else $error("no increment from 43h");
   a_incr_nmask: assert property (data_acc && ptr_q == IDX_NMSK1 |=> ptr_q == IDX_NMSK2)
      else $error("no increment from 45h");
   a_ptr_hold: assert property (data_acc && !pair_lo |=> $stable(ptr_q))
      else $error("pointer moved");
   a_irq_gate: assert property (!cfg_q[CFG_IRQEN_BIT] |=> mgmt_interrupt_out_n)
      else $error("interrupt driven while disabled");
   a_mask_block: assert property ((stat_q & ~mask_all) == 16'h0000
      |=> mgmt_interrupt_out_n)
      else $error("masked status raised interrupt");
   a_s2_quiet: assert property (s2_pend |-> !s2_evt)
      else $error("sensor 2 event while pending");
   a_s2_rearm: assert property (conv && !s2_two && s2_st_q == THERM_HOT
      && !t_lo && !s2_pend |=> stat_q[STAT_S2_BIT])
      else $error("comparator did not re-raise");
   a_ovt_cmp: assert property (conv && !ovt_int && t_hi |=> !overtemp_alert_out_n)
      else $error("comparator alert not asserted");
   a_ovt_release: assert property (temp_rd && ovt_int && !ovt_set
      |=> overtemp_alert_out_n)
      else $error("latched alert not released by read");

   // Two-times, latched re-arm and index read-back checks
   a_two_cold: assert property (conv && s2_two && s2_st_q == THERM_HOT && t_lo
      && !s2_pend |=> stat_q[STAT_S2_BIT])
      else $error("two-times cold event missing");
   a_two_quiet: assert property (conv && s2_two && s2_st_q == THERM_HOT
      && !t_lo |-> !s2_evt)
      else $error("two-times event while still warm");
   a_ovt_relatch: assert property (conv && ovt_int && ovt_st_q == THERM_HOT && t_lo
      |=> !overtemp_alert_out_n)
      else $error("latched alert not set on cooling");
   a_ovt_no_reassert: assert property (conv && ovt_int && ovt_st_q == THERM_HOT && !t_lo
      && overtemp_alert_out_n |=> overtemp_alert_out_n)
      else $error("latched alert reasserted while warm");
   a_idx_readback: assert property (port_req.rd && !port_req.sel
      |=> port_rdata_q[6:0] == $past(ptr_q))
      else $error("index read lost the pointer");
   a_busy_read: assert property (port_req.rd && !port_req.sel && serial_busy
      |=> port_rdata_q[BUSY_BIT])
      else $error("serial activity not shown as busy");

   c_s2_event: cover property (s2_evt ##2 mgmt_interrupt_out_n == 1'b0);
   c_ovt_latch: cover property (ovt_int && ovt_set ##[1:20] temp_rd);
   c_auto_incr: cover property (idx_wr ##1 data_acc && pair_lo ##1 data_acc);
   c_two_cold: cover property (conv && s2_two && s2_st_q == THERM_HOT && t_lo && !s2_pend);
   c_ovt_cmp: cover property (conv && !ovt_int && t_hi ##1 !overtemp_alert_out_n);
endmodule // hwm_core

//--- verif/hwm_host_model.sv
// Host model driving the monitor index and data ports
`timescale 1ns/1ns
module hwm_host_model (
   input wire logic ref_clk,
   input wire logic slow_mode,
   input wire logic [7:0] port_rdata_q,
   output hwm_pkg::hwm_port_req_t port_req
);
   import hwm_pkg::*;

   // Idle strobes from time zero
   initial begin
      port_req = '0;
   end

   // One port access, one strobe cycle; serial traffic is kept apart by the bench
   task automatic access(input logic sel, input logic rd, input logic [7:0] wdata,
                         output logic [7:0] rdata);
      int gap;
      gap = slow_mode ? $urandom_range(0, 3) : 0;
      repeat (gap) @(negedge ref_clk);
      @(negedge ref_clk);
      port_req = '{sel: sel, rd: rd, wr: !rd, wdata: wdata};
      @(negedge ref_clk);
      port_req.rd = 1'b0;
      port_req.wr = 1'b0;
      port_req.wdata = ~wdata; // Released data no longer shows the last byte
      @(negedge ref_clk);
      rdata = port_rdata_q; // Read data lands one edge after the strobe
   endtask
endmodule // hwm_host_model

//--- verif/test_hwm_core.sv
// Self-checking bench for the monitor port and alert block
`timescale 1ns/1ns
module test_hwm_core;
   import hwm_pkg::*;
   logic ref_clk = 1'b0;
   logic reset_n = 1'b0;
   logic slow_mode = 1'b0;
   hwm_port_req_t port_req;
   hwm_sense_t sense = '0;
   logic [15:0] status_evt = 16'h0000;
   logic serial_busy = 1'b0;
   logic [7:0] port_rdata_q;
   logic mgmt_interrupt_out_n;
   logic overtemp_alert_out_n;
   int error_cnt = 0;
   int checks = 0;
   logic [7:0] d;
   logic [7:0] v;
   logic [7:0] t;
   logic [6:0] a;
   logic [31:0] seed_ret;
   localparam logic [6:0] RST_IDX [11] = '{IDX_CFG, IDX_MASK1, IDX_MASK2, IDX_NMSK1,
      IDX_NMSK2, IDX_PROP, IDX_FANIO, IDX_FANDIV, IDX_BANK, IDX_DEVID, IDX_VENDOR};
   localparam logic [7:0] RST_VAL [11] = '{8'h08, 8'h00, 8'h00, 8'h00, 8'h40, 8'h00, 8'h15,
      8'h50, 8'h80, DEVICE_ID, VENDOR_HI};
   localparam logic [6:0] PTR_IDX [5] = '{IDX_CFG, IDX_STAT2, IDX_MASK1, IDX_NMSK1, IDX_STAT1};

   // Clock at 10 MHz
   initial begin
      forever #50 ref_clk = ~ref_clk;
   end

   hwm_core i_hwm_core (.ref_clk(ref_clk), .reset_n(reset_n), .port_req(port_req),
      .sense(sense), .status_evt(status_evt), .serial_busy(serial_busy),
      .port_rdata_q(port_rdata_q), .mgmt_interrupt_out_n(mgmt_interrupt_out_n),
      .overtemp_alert_out_n(overtemp_alert_out_n));
   hwm_host_model i_hwm_host_model (.ref_clk(ref_clk), .slow_mode(slow_mode),
      .port_rdata_q(port_rdata_q), .port_req(port_req));

   // Comparison and report helpers
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      checks++;
      if (seen !== exp) begin
         error_cnt++;
         $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic print_verdict();
      $display("Checks %0d, mismatches %0d", checks, error_cnt);
      if (error_cnt == 0 && checks > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask

   // Expected pointer after one data access
   function automatic logic [6:0] exp_ptr(input logic [6:0] i);
      return (i == 7'h41 || i == 7'h43 || i == 7'h45) ? i + 7'h01 : i;
   endfunction
   function automatic logic [7:0] hot_t();
      return 8'h51 + 8'($urandom_range(0, 46));
   endfunction
   function automatic logic [7:0] mid_t();
      return 8'h4B + 8'($urandom_range(0, 5));
   endfunction
   function automatic logic [7:0] cold_t();
      return 8'($urandom_range(0, 74));
   endfunction

   // Port access shorthands
   task automatic xfer(input logic sel, input logic rd, input logic [7:0] w);
      i_hwm_host_model.access(sel, rd, w, d);
   endtask
   task automatic wr_idx(input logic [6:0] i);
      xfer(1'b0, 1'b0, {1'b0, i});
   endtask
   task automatic rd_reg(input logic [6:0] i);
      wr_idx(i);
      xfer(1'b1, 1'b1, 8'h00);
   endtask
   task automatic wr_reg(input logic [6:0] i, input logic [7:0] w);
      wr_idx(i);
      xfer(1'b1, 1'b0, w);
   endtask
   task automatic rd_idx();
      xfer(1'b0, 1'b1, 8'h00);
   endtask
   task automatic clr_status();
      rd_reg(IDX_STAT1);
      xfer(1'b1, 1'b1, 8'h00);
      @(negedge ref_clk);
   endtask
   // One conversion pulse, then settle past the interrupt latency
   task automatic conv(input logic [7:0] tv);
      @(negedge ref_clk);
      sense = '{temp: tv, conv_done: 1'b1};
      @(negedge ref_clk);
      sense.conv_done = 1'b0;
      repeat (2) @(negedge ref_clk);
   endtask
   task automatic chk_m(input logic e);
      check({7'h00, mgmt_interrupt_out_n}, {7'h00, e});
   endtask
   task automatic chk_o(input logic e);
      check({7'h00, overtemp_alert_out_n}, {7'h00, e});
   endtask

   // Hang guard
   initial begin
      repeat (50000) @(posedge ref_clk);
      error_cnt++;
      $display("MISMATCH t=%0t run did not finish", $time);
      print_verdict();
   end

   // Main sequence
   initial begin
      seed_ret = $urandom(32'h5EC5);
      repeat (6) @(negedge ref_clk);
      reset_n = 1'b1;
      rd_idx();
      check(d, 8'h00);
      for (int k = 0; k < 11; k++) begin
         rd_reg(RST_IDX[k]);
         check(d, RST_VAL[k]);
      end
      // Busy flag from index writes and serial traffic
      wr_idx(IDX_CFG);
      rd_idx();
      check(d, 8'hC0);
      xfer(1'b1, 1'b1, 8'h00);
      rd_idx();
      check(d, 8'h40);
      serial_busy = 1'b1;
      rd_idx();
      check(d, 8'hC0);
      serial_busy = 1'b0;
      // Pointer after data accesses
      for (int k = 0; k < 5; k++) begin
         rd_reg(PTR_IDX[k]);
         rd_idx();
         check(d, {1'b0, exp_ptr(PTR_IDX[k])});
      end
      v = 8'($urandom);
      t = 8'($urandom);
      wr_reg(IDX_MASK1, v);
      xfer(1'b1, 1'b0, t);
      rd_idx();
      check(d, 8'h44);
      rd_reg(IDX_MASK1);
      check(d, v);
      xfer(1'b1, 1'b1, 8'h00);
      check(d, t & 8'h3F);
      slow_mode = 1'b1;
      for (int k = 0; k < 4; k++) begin
         a = 7'($urandom_range(0, 63));
         v = 8'($urandom);
         wr_reg(a, v);
         rd_idx();
         check(d, {1'b0, a});
         rd_reg(a);
         check(d, v);
      end
      wr_reg(IDX_MASK1, 8'h00);
      // Comparator interrupt and comparator over-temperature pin
      wr_reg(IDX_CFG, 8'h03);
      clr_status();
      conv(hot_t());
      chk_m(1'b0);
      chk_o(1'b0);
      conv(hot_t());
      rd_reg(IDX_STAT1);
      check(d & 8'h20, 8'h20);
      xfer(1'b1, 1'b1, 8'h00);
      @(negedge ref_clk);
      chk_m(1'b1);
      conv(mid_t());
      chk_m(1'b0);
      chk_o(1'b0);
      clr_status();
      conv(cold_t());
      chk_m(1'b1);
      chk_o(1'b1);
      // Two-times interrupt
      wr_reg(IDX_PROP, 8'h40);
      conv(hot_t());
      chk_m(1'b0);
      clr_status();
      conv(mid_t());
      chk_m(1'b1);
      conv(cold_t());
      chk_m(1'b0);
      clr_status();
      // Mask and enable gating
      wr_reg(IDX_MASK1, 8'h20);
      conv(hot_t());
      chk_m(1'b1);
      rd_reg(IDX_STAT1);
      check(d & 8'h20, 8'h20);
      clr_status();
      wr_reg(IDX_MASK1, 8'h00);
      wr_reg(IDX_CFG, 8'h01);
      conv(cold_t());
      chk_m(1'b1);
      clr_status();
      // Other status events leave the over-temperature pin alone
      for (int k = 0; k < 16; k++) begin
         @(negedge ref_clk);
         status_evt = 16'($urandom);
         chk_o(1'b1);
      end
      @(negedge ref_clk);
      status_evt = 16'h0000;
      clr_status();
      // Latched over-temperature pin on the sensor 2 page
      wr_reg(IDX_BANK, 8'h01);
      wr_reg(IDX_B_CFG, 8'h04);
      rd_reg(IDX_B_CFG);
      check(d, 8'h04);
      t = hot_t();
      conv(t);
      chk_o(1'b0);
      conv(hot_t());
      chk_o(1'b0);
      rd_reg(IDX_B_TEMP);
      @(negedge ref_clk);
      chk_o(1'b1);
      conv(mid_t());
      chk_o(1'b1);
      conv(cold_t());
      chk_o(1'b0);
      rd_reg(IDX_B_TLSB);
      @(negedge ref_clk);
      chk_o(1'b1);
      // Init bit restores the register defaults
      wr_reg(IDX_CFG, 8'h80);
      rd_reg(IDX_BANK);
      check(d, 8'h80);
      rd_reg(IDX_CFG);
      check(d, 8'h08);
      print_verdict();
   end
endmodule // test_hwm_core
